// *** lpcc_pkg.sv ***
// package: register map, codes and field layout for the led port pwm block
package lpcc_pkg;
  localparam int unsigned NPORT         = 10;
  localparam logic [7:0]  ADDR_PORT0    = 8'h00;
  localparam logic [7:0]  ADDR_PORT9    = 8'h09;
  localparam logic [7:0]  ADDR_IN_LOW   = 8'h0E;
  localparam logic [7:0]  ADDR_IN_HIGH  = 8'h0F;
  localparam logic [7:0]  ADDR_CONFIG   = 8'h10;
  localparam logic [7:0]  ADDR_SCALE_LO = 8'h13;
  localparam logic [7:0]  ADDR_SCALE_HI = 8'h14;
  localparam logic [7:0]  ADDR_GLOBAL   = 8'h15;
  // port register codes
  localparam logic [7:0]  CODE_LOW      = 8'h00;
  localparam logic [7:0]  CODE_HIGH     = 8'h01;
  localparam logic [7:0]  CODE_STATIC   = 8'h02;
  localparam logic [7:0]  CODE_OFF      = 8'hFF;
  // configuration bit positions
  localparam int unsigned CFG_RUN       = 0;
  localparam int unsigned CFG_STAGGER   = 5;
  localparam int unsigned CFG_PINRST    = 6;
  localparam int unsigned CFG_CLKSEL    = 7;
  // reset values, stagger phase step and pwm counter increment
  localparam logic [7:0]  RST_PORT      = 8'hFF;
  localparam logic [7:0]  RST_CONFIG    = 8'h80;
  localparam logic [7:0]  RST_SCALE     = 8'h00;
  localparam logic [7:0]  RST_GLOBAL    = 8'h07;
  localparam logic [7:0]  PHASE_STEP    = 8'h20;
  localparam logic [7:0]  PWM_ONE       = 8'h01;
  // host register access bundle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpcc_req_s;
endpackage

// *** lpcc_top.sv ***
// led port pwm generator with current scale, input readback and shutdown
// Function
// - global code D2..D0 sets full scale current
// - per-port scale bit, zero half, one full
// - config D7 chooses internal or external clock
// - pwm period is 256 pwm clock cycles
// - duty equals code over 256, codes 3..254
// - stagger off: all ports switch together
// - stagger on: ports offset by 32 counts
// - code 01 is input, readback shows pin
// - non-input ports read zero in input registers
// - input registers read-only, writes discarded
// - input bit layout P7..P0 and P9,P8
// - reset pin aborts serial transaction to idle
// - config D6: reset pin restores registers
// - reset pin low: serial bus ignored
// - only codes 00,01,FF means standby
// - per-port mirror on only while sinking
// - shutdown turns current ports off high-z
// - config D0 clear shutdown, set run
// - registers usable, unchanged across shutdown
// - shutdown edits act per port code immediately
// - decode 00 low, 01 high, 02 static, FF off
// - config D5 is stagger control
`timescale 1ns/1ps
module lpcc_top
  import lpcc_pkg::*;
(
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                RST,
  // register access from the serial slave
  input  wire lpcc_req_s           REQ,
  output logic      [7:0]          RDATA,
  output logic                     SERIAL_ABORT,
  // pin reset, active low, and variant strap
  input  wire logic                PIN_RESET_N,
  input  wire logic                HAS_CLOCK_PIN,
  // pwm clock sources, synchronous enables
  input  wire logic                INT_PWM_TICK,
  input  wire logic                EXT_PWM_CLOCK_IN,
  // port pins
  input  wire logic [NPORT-1:0]    PORT_LINE_IN,
  output logic      [NPORT-1:0]    PORT_LINE_OUT,
  output logic      [NPORT-1:0]    PORT_LINE_OE,
  // analog controls
  output logic      [NPORT-1:0]    MIRROR_EN,
  output logic      [NPORT-1:0]    FULL_SCALE,
  output logic      [2:0]          GLOBAL_LEVEL,
  output logic                     STANDBY
);

  // stored registers
  logic [7:0]  port_q [NPORT];     // per-port code
  logic [7:0]  config_q;           // configuration
  logic [7:0]  scale_lo_q;         // scale bits ports 0..7
  logic [7:0]  scale_hi_q;         // scale bits ports 8..9
  logic [7:0]  global_q;           // global current code
  logic [7:0]  pwm_cnt_q;          // shared pwm counter
  logic        ext_prev_q;         // external clock edge detect
  logic        rst_pin_q;          // registered pin reset level
  logic [7:0]  rdata_q;            // read data register
  logic [7:0]  rdata_d;
  logic [NPORT-1:0] out_q;         // pin drive levels
  logic [NPORT-1:0] oe_q;
  logic [NPORT-1:0] mirror_q;
  logic [NPORT-1:0] out_d;
  logic [NPORT-1:0] oe_d;
  logic [NPORT-1:0] mirror_d;

  // code classification, used for every port
  function automatic logic is_current(input logic [7:0] code);
    is_current = (code != CODE_LOW) && (code != CODE_HIGH) && (code != CODE_OFF);
  endfunction

  // port phase offset, ports 8 and 9 reuse phases 0 and 1
  function automatic logic [7:0] phase_of(input int unsigned n);
    phase_of = 8'((n % 8) * 32);
  endfunction

  // access qualification
  wire logic bus_live   = PIN_RESET_N;
  wire logic wr_ok      = REQ.wr && bus_live;
  wire logic rd_ok      = REQ.rd && bus_live;
  wire logic run        = config_q[CFG_RUN];
  wire logic stagger    = config_q[CFG_STAGGER];
  wire logic use_ext    = config_q[CFG_CLKSEL] && HAS_CLOCK_PIN;
  wire logic ext_rise   = EXT_PWM_CLOCK_IN && !ext_prev_q;
  wire logic pwm_tick   = use_ext ? ext_rise : INT_PWM_TICK;
  // falling pin reset restores when D6 set
  wire logic pin_fall   = rst_pin_q && !PIN_RESET_N;
  wire logic soft_por   = pin_fall && config_q[CFG_PINRST];
  // config write keeps read-only fields and variant rule on D7
  wire logic [7:0] cfg_wval = {REQ.wdata[7] && HAS_CLOCK_PIN, REQ.wdata[6:5],
                               3'h0, REQ.wdata[1:0]};

  // abort serial slave on pin reset
  assign SERIAL_ABORT = !PIN_RESET_N;

  // pwm counter: wraps every 256 ticks, one period
  // 256 count period
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pwm_cnt_q  <= 8'h00;
      ext_prev_q <= 1'b0;
      rst_pin_q  <= 1'b1;
    end else begin
      ext_prev_q <= EXT_PWM_CLOCK_IN;
      rst_pin_q  <= PIN_RESET_N;
      if (pwm_tick) begin
        pwm_cnt_q <= pwm_cnt_q + PWM_ONE;
      end
    end
  end

  // register file; shutdown never alters stored values
  // registers free in shutdown
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NPORT; i++) begin
        port_q[i] <= RST_PORT;
      end
      config_q   <= RST_CONFIG;
      scale_lo_q <= RST_SCALE;
      scale_hi_q <= RST_SCALE;
      global_q   <= RST_GLOBAL;
    end else if (soft_por) begin
      for (int i = 0; i < NPORT; i++) begin
        port_q[i] <= RST_PORT;
      end
      // variant without the clock pin stays on the internal source
      config_q   <= {HAS_CLOCK_PIN, 7'h00};
      scale_lo_q <= RST_SCALE;
      scale_hi_q <= RST_SCALE;
      global_q   <= RST_GLOBAL;
    end else if (wr_ok) begin
      if (REQ.addr <= ADDR_PORT9) begin
        port_q[4'(REQ.addr)] <= REQ.wdata;
      end
      if (REQ.addr == ADDR_CONFIG) begin
        config_q <= cfg_wval;
      end
      if (REQ.addr == ADDR_SCALE_LO) begin
        scale_lo_q <= REQ.wdata;
      end
      if (REQ.addr == ADDR_SCALE_HI) begin
        scale_hi_q <= REQ.wdata;
      end
      if (REQ.addr == ADDR_GLOBAL) begin
        global_q <= REQ.wdata;
      end
    end
  end

  // port output decode
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      logic [7:0] rel;
      rel = pwm_cnt_q;
      if (stagger) begin
        rel = pwm_cnt_q - phase_of(i);
      end
      out_d[i]    = 1'b1;
      oe_d[i]     = 1'b0;
      mirror_d[i] = 1'b0;
      if (port_q[i] == CODE_LOW) begin
        out_d[i] = 1'b0;
        oe_d[i]  = 1'b1;
      end else if (port_q[i] == CODE_HIGH || port_q[i] == CODE_OFF) begin
        // released pin; pull-up gives the high level
        oe_d[i] = 1'b0;
      end else if (run) begin
        if (port_q[i] == CODE_STATIC) begin
          mirror_d[i] = 1'b1;
        end else begin
          mirror_d[i] = rel < port_q[i];
        end
      end
    end
  end

  // input readback mux, non-input ports read zero
  // input register packing
  logic [NPORT-1:0] in_mask;
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      in_mask[i] = (port_q[i] == CODE_HIGH) && PORT_LINE_IN[i];
    end
  end

  // source bit readback; a variant without the clock pin always shows internal
  wire logic [7:0] cfg_view = {config_q[CFG_CLKSEL] && HAS_CLOCK_PIN, config_q[6:0]};

  // read data select
  always_comb begin
    rdata_d = rdata_q;
    if (rd_ok) begin
      rdata_d = 8'h00;
      if (REQ.addr <= ADDR_PORT9) begin
        rdata_d = port_q[4'(REQ.addr)];
      end else if (REQ.addr == ADDR_IN_LOW) begin
        rdata_d = in_mask[7:0];
      end else if (REQ.addr == ADDR_IN_HIGH) begin
        rdata_d = {6'h00, in_mask[9:8]};
      end else if (REQ.addr == ADDR_CONFIG) begin
        rdata_d = cfg_view;
      end else if (REQ.addr == ADDR_SCALE_LO) begin
        rdata_d = scale_lo_q;
      end else if (REQ.addr == ADDR_SCALE_HI) begin
        rdata_d = scale_hi_q;
      end else if (REQ.addr == ADDR_GLOBAL) begin
        rdata_d = global_q;
      end
    end
  end

  // output flops
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      out_q    <= '1;
      oe_q     <= '0;
      mirror_q <= '0;
      rdata_q  <= 8'h00;
    end else begin
      out_q    <= out_d;
      oe_q     <= oe_d;
      mirror_q <= mirror_d;
      rdata_q  <= rdata_d;
    end
  end

  assign GLOBAL_LEVEL  = global_q[2:0];
  assign FULL_SCALE    = {scale_hi_q[1:0], scale_lo_q};
  assign PORT_LINE_OUT = out_q;
  assign PORT_LINE_OE  = oe_q;
  assign MIRROR_EN     = mirror_q;
  assign RDATA         = rdata_q;

  // standby when no port holds a current code
  // standby detection
  always_comb begin
    STANDBY = 1'b1;
    for (int i = 0; i < NPORT; i++) begin
      if (is_current(port_q[i])) begin
        STANDBY = 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // run bit low, first of two shutdown cycles
  sequence s_shutdown_entry;
    !run;
  endsequence

  // pin reset seen high then low, the edge that may restore defaults
  sequence s_pin_drop;
    PIN_RESET_N ##1 !PIN_RESET_N;
  endsequence

  // port 4 running a pwm code, not logic, static or off
  sequence s_port4_pwm;
    run && (port_q[4] > CODE_STATIC) && (port_q[4] != CODE_OFF);
  endsequence

  AST_SHUTDOWN_OFF: assert property (s_shutdown_entry ##1 !run |-> MIRROR_EN == '0)
    else $error("mirror on in shutdown");
  AST_STANDBY_MIRROR: assert property (STANDBY && $past(STANDBY) |-> MIRROR_EN == '0)
    else $error("mirror on during standby");
  AST_STANDBY_EXIT: assert property (is_current(port_q[2]) |-> !STANDBY)
    else $error("standby with a current port");
  AST_IN_HIGH_ZERO: assert property (rd_ok && REQ.addr == ADDR_IN_HIGH
      |=> RDATA[7:2] == 6'h00)
    else $error("upper input bits nonzero");
  AST_IN_NOT_INPUT: assert property (rd_ok && REQ.addr == ADDR_IN_LOW
      && port_q[2] != CODE_HIGH |=> !RDATA[2])
    else $error("non-input port read as one");
  AST_INPUT_RO: assert property (wr_ok && REQ.addr == ADDR_IN_LOW && !soft_por
      |=> $stable(config_q) && $stable(global_q) && $stable(scale_lo_q))
    else $error("input write changed state");
  AST_BUS_IGNORED: assert property (!PIN_RESET_N && $past(!PIN_RESET_N)
      |=> $stable(global_q))
    else $error("write taken while held");
  AST_PIN_RESTORE: assert property (s_pin_drop ##0 config_q[CFG_PINRST]
      |=> global_q == RST_GLOBAL && scale_lo_q == RST_SCALE && !config_q[CFG_PINRST])
    else $error("pin reset did not restore");
  AST_PIN_KEEP: assert property (s_pin_drop ##0 !config_q[CFG_PINRST]
      |=> $stable(scale_lo_q) && $stable(config_q))
    else $error("pin reset changed registers");
  AST_LOW_DRIVES: assert property (port_q[1] == CODE_LOW
      |=> PORT_LINE_OE[1] && !PORT_LINE_OUT[1])
    else $error("low code not driven");
  AST_SHUTDOWN_HIGHZ: assert property (!run && port_q[2] == CODE_STATIC
      |=> !PORT_LINE_OE[2] && !MIRROR_EN[2])
    else $error("current port active in shutdown");
  AST_ABORT: assert property (!PIN_RESET_N |-> SERIAL_ABORT)
    else $error("abort missing");
  AST_CLK_VARIANT: assert property (!HAS_CLOCK_PIN && $past(!HAS_CLOCK_PIN)
      |-> !use_ext)
    else $error("external clock used");
  AST_COUNT_HOLD: assert property (!pwm_tick |=> $stable(pwm_cnt_q))
    else $error("pwm counter moved without tick");
  AST_PWM_WRAP: assert property (pwm_tick && pwm_cnt_q == 8'hFF |=> pwm_cnt_q == 8'h00)
    else $error("pwm counter did not wrap");
  AST_INPHASE_START: assert property (s_port4_pwm ##0 (!stagger
      && pwm_cnt_q == 8'h00) |=> MIRROR_EN[4])
    else $error("unstaggered port not on at zero");
  AST_STAGGER_START: assert property (s_port4_pwm ##0 (stagger
      && pwm_cnt_q == PHASE_STEP * 8'h04) |=> MIRROR_EN[4])
    else $error("staggered port not on at its phase");
  AST_STAGGER_BEFORE: assert property (s_port4_pwm ##0 (stagger
      && pwm_cnt_q == PHASE_STEP * 8'h04 - 8'h01) |=> !MIRROR_EN[4])
    else $error("staggered port on before its phase");
  AST_STATIC_ON: assert property (run && port_q[2] == CODE_STATIC
      ##1 $stable(port_q[2]) && run |-> MIRROR_EN[2])
    else $error("static port not on");

endmodule

// *** lpcc_pin_model.sv ***
// open-drain port pins with pull-ups and an outside logic source
`timescale 1ns/1ps
module lpcc_pin_model
  import lpcc_pkg::*;
(
  // design side
  input  wire logic [NPORT-1:0] oe,
  // outside source, enable and level
  input  wire logic [NPORT-1:0] src_en,
  input  wire logic [NPORT-1:0] src_lvl,
  // resolved pin level
  output logic      [NPORT-1:0] line
);
  // a port sinking wins, else the source, else the pull-up
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      line[i] = oe[i] ? 1'b0 : (src_en[i] ? src_lvl[i] : 1'b1);
    end
  end
endmodule

// *** lpcc_tb.sv ***
// bench: register access, pin readback, shutdown, pwm and pin reset
`timescale 1ns/1ps
module led_port_pwm_current_control_tb_top;
  import lpcc_pkg::*;
  logic             mclk = 1'b0;
  logic             rst = 1'b1;
  lpcc_req_s        req = '0;
  logic             prst_n = 1'b1;
  logic             has_pin = 1'b1;
  logic             ext_clk = 1'b0;
  logic [NPORT-1:0] src_en = '1;
  logic [NPORT-1:0] src_lvl = '1;
  logic [7:0]       rdata, v;
  logic             abort, stby;
  logic [NPORT-1:0] line, out, oe, mir, fs;
  logic [2:0]       glev;
  int               failures = 0;
  int               n_checks = 0;
  int               cnt, both;
  always #2 mclk = ~mclk;
  // external pwm clock: one rising edge every two system clocks
  always @(posedge mclk) ext_clk <= ~ext_clk;
  lpcc_top dut_u (.MCLK(mclk), .RST(rst), .REQ(req), .RDATA(rdata), .SERIAL_ABORT(abort),
    .PIN_RESET_N(prst_n), .HAS_CLOCK_PIN(has_pin), .INT_PWM_TICK(1'b1),
    .EXT_PWM_CLOCK_IN(ext_clk),
    .PORT_LINE_IN(line), .PORT_LINE_OUT(out), .PORT_LINE_OE(oe), .MIRROR_EN(mir),
    .FULL_SCALE(fs), .GLOBAL_LEVEL(glev), .STANDBY(stby));
  lpcc_pin_model pins_u (.oe(oe), .src_en(src_en), .src_lvl(src_lvl), .line(line));
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write, returns once outputs have followed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) req <= '0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // read data is valid the cycle after the request is taken
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) req <= '0;
    #1 chk(what, 16'(rdata), 16'(exp));
  endtask
  // mirror on-cycles over n system clocks, one full pwm period
  task automatic meas(input int a, input int b, input int n);
    cnt = 0;
    both = 0;
    repeat (n) begin
      @(posedge mclk);
      #1 cnt += int'(mir[a]);
      both += int'(mir[a] & mir[b]);
    end
  endtask
  // pin reset pulse, with a write that must be refused meanwhile
  task automatic pulse();
    @(posedge mclk) prst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("abort", 16'(abort), 16'h0001);
    wr(ADDR_SCALE_LO, 8'h3C);
    @(posedge mclk) prst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rchk("glob", ADDR_GLOBAL, RST_GLOBAL);
    rchk("cfg", ADDR_CONFIG, RST_CONFIG);
    wr(ADDR_GLOBAL, 8'hF3);
    chk("glev", 16'(glev), 16'h0003);
    wr(ADDR_SCALE_LO, 8'hA5);
    wr(ADDR_SCALE_HI, 8'h02);
    chk("fs", 16'(fs), 16'h02A5);
    $display("test currents done");
    wr(8'h00, CODE_HIGH);
    wr(8'h03, CODE_HIGH);
    wr(ADDR_PORT9, CODE_HIGH);
    wr(8'h01, CODE_LOW);
    chk("oe1", 16'(oe), 16'h0002);
    chk("out1", 16'(out), 16'h03FD);
    chk("stby", 16'(stby), 16'h0001);
    rchk("inlo", ADDR_IN_LOW, 8'h09);
    rchk("inhi", ADDR_IN_HIGH, 8'h02);
    @(posedge mclk) src_lvl <= 10'h3F7;
    repeat (4) @(posedge mclk);
    wr(ADDR_IN_LOW, 8'hFF);
    rchk("inlo2", ADDR_IN_LOW, 8'h01);
    $display("test inputs done");
    wr(8'h02, CODE_STATIC);
    chk("mir_sd", 16'(mir), 16'h0000);
    chk("stby0", 16'(stby), 16'h0000);
    wr(ADDR_CONFIG, 8'h01);
    chk("mir_run", 16'(mir), 16'h0004);
    chk("oe_run", 16'(oe), 16'h0002);
    rchk("p2", 8'h02, CODE_STATIC);
    wr(ADDR_CONFIG, 8'h00);
    wr(8'h02, CODE_OFF);
    $display("test shutdown done");
    wr(8'h04, 8'h80);
    wr(8'h05, 8'h80);
    wr(ADDR_CONFIG, 8'h01);
    meas(4, 5, 256);
    chk("duty", 16'(cnt), 16'h0080);
    chk("inph", 16'(both), 16'h0080);
    // stagger only touched while shut down
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_CONFIG, 8'h20);
    wr(ADDR_CONFIG, 8'h21);
    meas(4, 5, 256);
    chk("stag", 16'(both), 16'h0060);
    wr(8'h04, 8'h03);
    meas(4, 5, 256);
    chk("duty3", 16'(cnt), 16'h0003);
    // external source: one count per two clocks, so the period doubles
    wr(ADDR_CONFIG, 8'h00);
    wr(8'h04, 8'h80);
    wr(ADDR_CONFIG, 8'h81);
    meas(4, 5, 512);
    chk("ext", 16'(cnt), 16'h0100);
    chk("extph", 16'(both), 16'h0100);
    $display("test pwm done");
    // single device, so its reset pin alone selects it
    pulse();
    rchk("keep", ADDR_SCALE_LO, 8'hA5);
    wr(ADDR_CONFIG, 8'h40);
    pulse();
    rchk("rglob", ADDR_GLOBAL, RST_GLOBAL);
    rchk("rp4", 8'h04, RST_PORT);
    rchk("rcfg", ADDR_CONFIG, RST_CONFIG);
    rchk("rlo", ADDR_SCALE_LO, RST_SCALE);
    $display("test pin reset done");
    // variant without the clock pin: the source bit cannot be set
    @(posedge mclk) has_pin <= 1'b0;
    wr(ADDR_CONFIG, 8'h81);
    rchk("nopin", ADDR_CONFIG, 8'h01);
    $display("test clock variant done");
    complete_run();
  end
  // watchdog, far beyond the roughly 1450 cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    complete_run();
  end
endmodule
